// File: core/lapb_pkg.sv
// Constants, register selects and state enums for the link controller.
// Assumes a single 50 MHz core clock and a synchronous active-high reset.
package lapb_pkg;

  // ----------------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_W  = 28;
  localparam int I_CTS   = 0;
  localparam int I_CD    = 1;
  localparam int I_PAR   = 2;
  localparam int I_CREQ  = 3;
  localparam int I_GNT   = 4;
  localparam int I_RDY   = 5;
  localparam int I_CS    = 6;
  localparam int I_STB   = 7;
  localparam int I_RW    = 8;
  localparam int I_WE    = 9;
  localparam int I_TXC   = 10;
  localparam int I_RXC   = 11;
  localparam int I_RXD   = 12;
  localparam int I_STRAP = 13;
  localparam int I_DIN   = 14;
  localparam int I_SEL   = 22;

  // ----------------------------------------------------------------
  // Register selects and fields
  // ----------------------------------------------------------------
  localparam logic [5:0] SEL_IRQ  = 6'h00;
  localparam logic [5:0] SEL_CTRL = 6'h01;
  localparam logic [5:0] SEL_TXD  = 6'h02;
  localparam logic [5:0] SEL_RXD  = 6'h03;
  localparam logic [5:0] SEL_STAT = 6'h04;
  localparam logic [5:0] SEL_ADRL = 6'h05;
  localparam logic [5:0] SEL_ADRH = 6'h06;

  localparam int IRQ_W   = 5;
  localparam int IRQ_CD  = 0;
  localparam int IRQ_CTS = 1;
  localparam int IRQ_HPE = 2;
  localparam int IRQ_RX  = 3;
  localparam int IRQ_TX  = 4;

  localparam int CTRL_LINK = 0;
  localparam int CTRL_DMA  = 1;

  localparam int ST_LINK = 0;
  localparam int ST_CTS  = 1;
  localparam int ST_CD   = 2;
  localparam int ST_TXF  = 3;
  localparam int ST_RXF  = 4;
  localparam int ST_MODE = 5;

  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] FLAG_BYTE   = 8'h7e;
  localparam logic [7:0] ABORT_BYTE  = 8'hff;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [2:0] ONES_MAX    = 3'h7;
  localparam logic [1:0] HARD_STRIKE = 2'h2;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic {BUS_STROBE_RW, BUS_RD_WR} bus_mode_t;
  typedef enum logic {H_IDLE, H_DONE} host_st_t;
  typedef enum logic [1:0] {D_IDLE, D_REQ, D_ACCESS, D_END} dma_st_t;

endpackage

// File: core/sync_bits.sv
// Two-flop synchroniser for a vector of unrelated asynchronous levels.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/10ps
module sync_bits #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
  } sync_state_t;

  sync_state_t s_ff;
  sync_state_t nxt_s;

  always_comb
  begin
    nxt_s.meta_ff = async_in;
    nxt_s.sync_ff = s_ff.meta_ff;
  end

  always_ff @(posedge core_clk)
  begin
    s_ff <= nxt_s;
  end

  assign sync_out = s_ff.sync_ff;
endmodule // sync_bits

// File: core/lapb_link_ctrl.sv
// Pin-level link controller: host register port, DMA master with daisy
// chain, HDLC-style serial framer and modem handshakes.
// Assumes pins are asynchronous to core_clk and bit clocks run far slower.
//
// How it works
// - Flag-delimited, bit-stuffed synchronous full-duplex framing.
// - Serial data handled byte-wise, up to 250 kb/s.
// - Separate external 1x transmit and receive bit clocks.
// - Host data bus carries registers and DMA.
// - Register access only while chip select low.
// - Reset floats every output, clears logic.
// - Bus convention strapped at reset, held after.
// - Interrupt low while pending; register read clears.
// - Two consecutive parity faults raise hard error.
// - Every carrier-detect transition raises an interrupt.
// - Carrier level otherwise affects nothing.
// - Link stays down until clear-to-send low.
// - Clear-to-send loss drops link, interrupts.
// - Request-to-send low while link up.
// - Unused grants passed on down chain.
// - Bus request low asks for system bus.
// - Grant makes strobes and address outputs.
// - Ready low ends register access; DMA waits.
`timescale 1ns/10ps
module lapb_link_ctrl
  import lapb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  host_data_bus_in,
  output logic      [7:0]  host_data_bus_out,
  output logic             host_data_bus_oe_n,
  input  wire logic [5:0]  register_select,
  output logic      [15:0] addr_out,
  input  wire logic        chip_select_n,
  input  wire logic        rw_in,
  output logic             rw_out,
  input  wire logic        strobe_in_n,
  output logic             strobe_out_n,
  input  wire logic        we_in_n,
  output logic             we_out_n,
  output logic             as_out_n,
  output logic             dma_oe_n,
  input  wire logic        ready_in_n,
  output logic             ready_out_n,
  output logic             ready_oe_n,
  input  wire logic        bus_mode_strap,
  output logic             bus_request_n,
  input  wire logic        bus_grant_n,
  input  wire logic        chain_request_in,
  output logic             chain_grant_out,
  input  wire logic        parity_fault_in,
  input  wire logic        carrier_sense_n,
  input  wire logic        clear_to_send_n,
  output logic             request_to_send_n,
  input  wire logic        tx_bit_clock,
  input  wire logic        rx_bit_clock,
  output logic             serial_tx_out,
  input  wire logic        serial_rx_in,
  output logic             irq_request_n,
  output logic             pin_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_mode_t        mode;
    logic [7:0]       ctrl;
    logic [IRQ_W-1:0] irq;
    logic             link_up;
    logic             cd_prev;
    logic             txc_prev;
    logic             rxc_prev;
    logic [7:0]       tx_hold;
    logic             tx_full;
    logic [7:0]       tx_sh;
    logic [2:0]       tx_cnt;
    logic             tx_flag;
    logic [2:0]       tx_ones;
    logic             tx_out;
    logic [7:0]       rx_hist;
    logic [7:0]       rx_sh;
    logic [2:0]       rx_cnt;
    logic [2:0]       rx_ones;
    logic             rx_frame;
    logic [7:0]       rx_data;
    logic             rx_full;
    logic [15:0]      addr;
    dma_st_t          dma;
    logic [1:0]       strikes;
    logic             own_req;
    host_st_t         host;
    logic [7:0]       dout;
    logic             dout_oe_n;
    logic             ready_oe_n;
    logic             bus_oe_n;
    logic             as_n;
    logic             strobe_n;
    logic             we_n;
    logic             rw;
    logic             req_n;
    logic             chain_gnt_n;
    logic             irq_n;
    logic             rts_n;
    logic             pins_oe_n;
  } state_t;

  state_t            s_ff;
  state_t            nxt_s;
  logic [SYNC_W-1:0] sy;
  logic [7:0]        rd_val;
  logic [7:0]        stat;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic              sel;
  logic              rd_req;
  logic              wr_req;
  logic [7:0]        din;
  logic [5:0]        rsel;
  logic              rx_bit;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  sync_bits #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .async_in ({register_select, host_data_bus_in, bus_mode_strap, serial_rx_in,
                rx_bit_clock, tx_bit_clock, we_in_n, rw_in, strobe_in_n,
                chip_select_n, ready_in_n, bus_grant_n, chain_request_in,
                parity_fault_in, carrier_sense_n, clear_to_send_n}),
    .sync_out (sy)
  );

  assign din    = sy[I_DIN +: 8];
  assign rsel   = sy[I_SEL +: 6];
  assign rx_bit = sy[I_RXD];
  assign sel    = !sy[I_CS];

  // ----------------------------------------------------------------
  // Host decode and read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    if (s_ff.mode == BUS_STROBE_RW)
    begin
      rd_req = sel && !sy[I_STB] && sy[I_RW];
      wr_req = sel && !sy[I_STB] && !sy[I_RW];
    end
    else
    begin
      rd_req = sel && !sy[I_STB];
      wr_req = sel && !sy[I_WE];
    end
    stat          = 8'h00;
    stat[ST_LINK] = s_ff.link_up;
    stat[ST_CTS]  = !sy[I_CTS];
    stat[ST_CD]   = !sy[I_CD];
    stat[ST_TXF]  = s_ff.tx_full;
    stat[ST_RXF]  = s_ff.rx_full;
    stat[ST_MODE] = (s_ff.mode == BUS_RD_WR);
    unique case (rsel)
      SEL_IRQ:  rd_val = {{(8-IRQ_W){1'b0}}, s_ff.irq};
      SEL_CTRL: rd_val = s_ff.ctrl;
      SEL_TXD:  rd_val = s_ff.tx_hold;
      SEL_RXD:  rd_val = s_ff.rx_data;
      SEL_STAT: rd_val = stat;
      SEL_ADRL: rd_val = s_ff.addr[7:0];
      SEL_ADRH: rd_val = s_ff.addr[15:8];
      default:  rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s   = s_ff;
    irq_set = '0;
    irq_clr = '0;
    nxt_s.cd_prev  = sy[I_CD];
    nxt_s.txc_prev = sy[I_TXC];
    nxt_s.rxc_prev = sy[I_RXC];

    // Carrier edges only interrupt, never steer the link
    if (sy[I_CD] != s_ff.cd_prev)
      irq_set[IRQ_CD] = 1'b1;

    // Link supervision
    if (!s_ff.ctrl[CTRL_LINK])
      nxt_s.link_up = 1'b0;
    else if (s_ff.link_up && sy[I_CTS])
    begin
      nxt_s.link_up    = 1'b0;
      irq_set[IRQ_CTS] = 1'b1;
    end
    else if (!s_ff.link_up && !sy[I_CTS])
      nxt_s.link_up = 1'b1;
    nxt_s.rts_n = !nxt_s.link_up;

    // Transmitter: shifts on falling edge of external bit clock
    if (!s_ff.link_up)
    begin
      nxt_s.tx_sh   = FLAG_BYTE;
      nxt_s.tx_flag = 1'b1;
      nxt_s.tx_cnt  = 3'h0;
      nxt_s.tx_ones = 3'h0;
      nxt_s.tx_out  = 1'b1;
    end
    else if (s_ff.txc_prev && !sy[I_TXC])
    begin
      if (s_ff.tx_ones == STUFF_LIMIT)
      begin
        nxt_s.tx_out  = 1'b0;
        nxt_s.tx_ones = 3'h0;
      end
      else
      begin
        nxt_s.tx_out  = s_ff.tx_sh[0];
        nxt_s.tx_ones = (s_ff.tx_flag || !s_ff.tx_sh[0]) ? 3'h0 : s_ff.tx_ones + 3'h1;
        nxt_s.tx_sh   = {1'b0, s_ff.tx_sh[7:1]};
        nxt_s.tx_cnt  = s_ff.tx_cnt + 3'h1;
        if (s_ff.tx_cnt == 3'h7)
        begin
          if (s_ff.tx_full)
          begin
            nxt_s.tx_sh     = s_ff.tx_hold;
            nxt_s.tx_flag   = 1'b0;
            nxt_s.tx_full   = 1'b0;
            irq_set[IRQ_TX] = 1'b1;
          end
          else
          begin
            nxt_s.tx_sh   = FLAG_BYTE;
            nxt_s.tx_flag = 1'b1;
          end
        end
      end
    end

    // Host register port; ready held until strobe, or write enable for writes in the read/write-enable convention, released
    unique case (s_ff.host)
      H_IDLE:
        if ((rd_req || wr_req) && s_ff.bus_oe_n)
        begin
          nxt_s.host       = H_DONE;
          nxt_s.ready_oe_n = 1'b0;
          if (rd_req)
          begin
            nxt_s.dout      = rd_val;
            nxt_s.dout_oe_n = 1'b0;
            if (rsel == SEL_IRQ)
              irq_clr = s_ff.irq;
            if (rsel == SEL_RXD)
              nxt_s.rx_full = 1'b0;
          end
          else
          begin
            unique case (rsel)
              SEL_CTRL: nxt_s.ctrl = din;
              SEL_TXD:
              begin
                nxt_s.tx_hold = din;
                nxt_s.tx_full = 1'b1;
              end
              SEL_ADRL: nxt_s.addr[7:0] = din;
              SEL_ADRH: nxt_s.addr[15:8] = din;
              default: ;
            endcase
          end
        end
      H_DONE:
        if (!(rd_req || wr_req))
        begin
          nxt_s.host       = H_IDLE;
          nxt_s.ready_oe_n = 1'b1;
          nxt_s.dout_oe_n  = 1'b1;
        end
    endcase

    // DMA: each received byte is written to memory, or dropped after two parity faults in a row
    unique case (s_ff.dma)
      D_IDLE:
        if (s_ff.ctrl[CTRL_DMA] && s_ff.rx_full && s_ff.link_up)
        begin
          nxt_s.own_req = 1'b1;
          nxt_s.dma     = D_REQ;
        end
      D_REQ:
        if (!sy[I_GNT] && !sel)
        begin
          nxt_s.bus_oe_n  = 1'b0;
          nxt_s.as_n      = 1'b0;
          nxt_s.rw        = 1'b0;
          nxt_s.dout      = s_ff.rx_data;
          nxt_s.dout_oe_n = 1'b0;
          if (s_ff.mode == BUS_STROBE_RW)
            nxt_s.strobe_n = 1'b0;
          else
            nxt_s.we_n = 1'b0;
          nxt_s.dma = D_ACCESS;
        end
      D_ACCESS:
        // Wait states until memory answers
        if (!sy[I_RDY])
        begin
          nxt_s.as_n      = 1'b1;
          nxt_s.strobe_n  = 1'b1;
          nxt_s.we_n      = 1'b1;
          nxt_s.dout_oe_n = 1'b1;
          nxt_s.dma       = D_END;
          if (sy[I_PAR])
          begin
            nxt_s.strikes = s_ff.strikes + 2'h1;
            if (s_ff.strikes + 2'h1 == HARD_STRIKE)
            begin
              irq_set[IRQ_HPE] = 1'b1;
              nxt_s.rx_full    = 1'b0;
              nxt_s.strikes    = 2'h0;
            end
          end
          else
          begin
            nxt_s.strikes = 2'h0;
            nxt_s.rx_full = 1'b0;
            nxt_s.addr    = s_ff.addr + 16'h0001;
          end
        end
      D_END:
      begin
        // A first failed attempt retries from idle with the same byte; a second in a row drops it
        nxt_s.bus_oe_n = 1'b1;
        nxt_s.rw       = 1'b1;
        nxt_s.own_req  = 1'b0;
        nxt_s.dma      = D_IDLE;
      end
    endcase

    // Receiver: samples on rising edge of external bit clock
    if (!s_ff.link_up)
      nxt_s.rx_frame = 1'b0;
    else if (!s_ff.rxc_prev && sy[I_RXC])
    begin
      nxt_s.rx_hist = {rx_bit, s_ff.rx_hist[7:1]};
      if (nxt_s.rx_hist == FLAG_BYTE)
      begin
        nxt_s.rx_frame = 1'b1;
        nxt_s.rx_cnt   = 3'h0;
        nxt_s.rx_ones  = 3'h0;
      end
      else if (nxt_s.rx_hist == ABORT_BYTE)
        nxt_s.rx_frame = 1'b0;
      else if (s_ff.rx_ones == STUFF_LIMIT && !rx_bit)
        nxt_s.rx_ones = 3'h0;
      else
      begin
        nxt_s.rx_ones = !rx_bit ? 3'h0 :
                        (s_ff.rx_ones == ONES_MAX) ? ONES_MAX : s_ff.rx_ones + 3'h1;
        nxt_s.rx_sh   = {rx_bit, s_ff.rx_sh[7:1]};
        nxt_s.rx_cnt  = s_ff.rx_cnt + 3'h1;
        if (s_ff.rx_cnt == 3'h7 && s_ff.rx_frame)
        begin
          nxt_s.rx_data   = nxt_s.rx_sh;
          nxt_s.rx_full   = 1'b1;
          irq_set[IRQ_RX] = 1'b1;
        end
      end
    end

    // A new event wins over a clearing read in the same cycle
    nxt_s.irq   = (s_ff.irq & ~irq_clr) | irq_set;
    nxt_s.irq_n = !(|nxt_s.irq);

    // Downstream request rides on ours; idle grants go down chain
    nxt_s.req_n       = !(nxt_s.own_req || !sy[I_CREQ]);
    nxt_s.chain_gnt_n = !(!sy[I_GNT] && !nxt_s.own_req);
    nxt_s.pins_oe_n   = 1'b0;

    // Reset floats all pins and catches the bus convention strap
    if (rst)
    begin
      nxt_s             = '0;
      nxt_s.mode        = sy[I_STRAP] ? BUS_RD_WR : BUS_STROBE_RW;
      nxt_s.ctrl        = CTRL_RST;
      nxt_s.host        = H_IDLE;
      nxt_s.dma         = D_IDLE;
      nxt_s.tx_sh       = FLAG_BYTE;
      nxt_s.tx_flag     = 1'b1;
      nxt_s.tx_out      = 1'b1;
      nxt_s.cd_prev     = sy[I_CD];
      nxt_s.dout_oe_n   = 1'b1;
      nxt_s.ready_oe_n  = 1'b1;
      nxt_s.bus_oe_n    = 1'b1;
      nxt_s.as_n        = 1'b1;
      nxt_s.strobe_n    = 1'b1;
      nxt_s.we_n        = 1'b1;
      nxt_s.rw          = 1'b1;
      nxt_s.req_n       = 1'b1;
      nxt_s.chain_gnt_n = 1'b1;
      nxt_s.irq_n       = 1'b1;
      nxt_s.rts_n       = 1'b1;
      nxt_s.pins_oe_n   = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign host_data_bus_out  = s_ff.dout;
  assign host_data_bus_oe_n = s_ff.dout_oe_n;
  assign addr_out           = s_ff.addr;
  assign rw_out             = s_ff.rw;
  assign strobe_out_n       = s_ff.strobe_n;
  assign we_out_n           = s_ff.we_n;
  assign as_out_n           = s_ff.as_n;
  assign dma_oe_n           = s_ff.bus_oe_n;
  assign ready_out_n        = s_ff.ready_oe_n;
  assign ready_oe_n         = s_ff.ready_oe_n;
  assign bus_request_n      = s_ff.req_n;
  assign chain_grant_out    = s_ff.chain_gnt_n;
  assign request_to_send_n  = s_ff.rts_n;
  assign serial_tx_out      = s_ff.tx_out;
  assign irq_request_n      = s_ff.irq_n;
  assign pin_oe_n           = s_ff.pins_oe_n;
endmodule // lapb_link_ctrl

// File: tb/lapb_link_ctrl_sva.sv
// Checker on the link controller pins.
// Assumes one clock domain; bound onto every lapb_link_ctrl.
`timescale 1ns/10ps
module lapb_link_ctrl_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_oe_n,
  input wire logic ready_oe_n,
  input wire logic host_data_bus_oe_n,
  input wire logic dma_oe_n,
  input wire logic as_out_n,
  input wire logic clear_to_send_n,
  input wire logic request_to_send_n,
  input wire logic carrier_sense_n,
  input wire logic irq_request_n,
  input wire logic bus_grant_n,
  input wire logic chain_grant_out,
  input wire logic chain_request_in,
  input wire logic bus_request_n,
  input wire logic chip_select_n
);
  // ----
  // Assertions
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_float: assert property (
    disable iff (1'b0) rst && $past(rst) |-> pin_oe_n && ready_oe_n && dma_oe_n
      && host_data_bus_oe_n) else $error("outputs driven in reset");
  a_cts_gate: assert property (
    clear_to_send_n [*6] |-> request_to_send_n) else $error("link up without cts");
  a_carrier_irq: assert property (
    $changed(carrier_sense_n) |-> ##[1:6] !irq_request_n) else $error("no carrier irq");
  a_chain_pass: assert property (
    bus_grant_n [*4] |-> chain_grant_out) else $error("grant passed without grant");
  a_chain_req: assert property (
    !chain_request_in [*4] |-> !bus_request_n) else $error("chain request lost");
  a_cs_ready: assert property (
    chip_select_n [*5] |-> ready_oe_n) else $error("ready driven unselected");
  a_dma_grant: assert property (
    bus_grant_n [*4] |-> dma_oe_n) else $error("dma lines driven ungranted");
  a_as_oe: assert property (
    !as_out_n |-> !dma_oe_n) else $error("strobe while floating");
  a_no_clash: assert property (
    !dma_oe_n |-> ready_oe_n) else $error("ready driven during dma");
  a_data_src: assert property (
    !host_data_bus_oe_n |-> !ready_oe_n || !dma_oe_n) else $error("stray data drive");
endmodule // lapb_link_ctrl_sva

bind lapb_link_ctrl lapb_link_ctrl_sva u_sva (
  .core_clk, .rst, .pin_oe_n, .ready_oe_n, .host_data_bus_oe_n, .dma_oe_n,
  .as_out_n, .clear_to_send_n, .request_to_send_n, .carrier_sense_n,
  .irq_request_n, .bus_grant_n, .chain_grant_out, .chain_request_in,
  .bus_request_n, .chip_select_n
);

// File: tb/modem_model.sv
// Modem side: 1x bit clocks, receive frames, transmit monitor.
// Assumes tx clock runs free; rx clock only within frames.
`timescale 1ns/10ps
module modem_model (
  output logic      tx_bit_clock,
  output logic      rx_bit_clock,
  output logic      serial_rx_in,
  input  wire logic serial_tx_out
);
  logic [7:0] tx_sh;
  logic       flag_seen;
  initial
  begin
    tx_bit_clock = 1'b0;
    rx_bit_clock = 1'b0;
    serial_rx_in = 1'b1;
    tx_sh = 8'h00;
    flag_seen = 1'b0;
    forever #80 tx_bit_clock = ~tx_bit_clock;
  end
  // Sample mid-bit, LSB first
  always @(posedge tx_bit_clock)
  begin
    tx_sh = {serial_tx_out, tx_sh[7:1]};
    if (tx_sh == 8'h7e)
      flag_seen = 1'b1;
  end
  task automatic send_bit(input logic b);
    serial_rx_in = b;
    #80 rx_bit_clock = 1'b1;
    #80 rx_bit_clock = 1'b0;
  endtask
  // No stuffing: callers pick bytes without five ones in a row
  task automatic send_frame(input logic [7:0] d);
    logic [23:0] f;
    f = {8'h7e, d, 8'h7e};
    for (int i = 0; i < 24; i++)
      send_bit(f[i]);
    serial_rx_in = 1'b1;
  endtask
endmodule // modem_model

// File: tb/testbench.sv
// Self-checking bench: register port, link, carrier, DMA, chain.
// Assumes one memory; the strap picks the bus convention at each reset.
`timescale 1ns/10ps
module testbench;
  import lapb_pkg::*;
  logic        core_clk, rst, chip_select_n, rw_in, strobe_in_n, ready_in_n;
  logic        bus_grant_n, chain_request_in, parity_fault_in, we_in_n, bus_mode_strap;
  logic        carrier_sense_n, clear_to_send_n;
  logic        tx_bit_clock, rx_bit_clock, serial_rx_in, serial_tx_out;
  logic        host_data_bus_oe_n, rw_out, strobe_out_n, we_out_n, as_out_n;
  logic        dma_oe_n, ready_out_n, ready_oe_n, bus_request_n, chain_grant_out;
  logic        request_to_send_n, irq_request_n, pin_oe_n;
  logic [7:0]  host_data_bus_in, host_data_bus_out, rd, dd;
  logic [5:0]  register_select;
  logic [15:0] addr_out, aa;
  int          mismatches, n_checks;

  lapb_link_ctrl DUT (
    .core_clk, .rst, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n,
    .register_select, .addr_out, .chip_select_n, .rw_in, .rw_out, .strobe_in_n,
    .strobe_out_n, .we_in_n, .we_out_n, .as_out_n, .dma_oe_n, .ready_in_n,
    .ready_out_n, .ready_oe_n, .bus_mode_strap, .bus_request_n, .bus_grant_n,
    .chain_request_in, .chain_grant_out, .parity_fault_in, .carrier_sense_n,
    .clear_to_send_n, .request_to_send_n, .tx_bit_clock, .rx_bit_clock,
    .serial_tx_out, .serial_rx_in, .irq_request_n, .pin_oe_n
  );
  modem_model M (.tx_bit_clock, .rx_bit_clock, .serial_rx_in, .serial_tx_out);

  // ----
  // Helpers
  // ----
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return ready_oe_n;
      1: return irq_request_n;
      2: return bus_request_n;
      3: return chain_grant_out;
      default: return strobe_out_n & we_out_n;
    endcase
  endfunction
  // Bounded wait; a hang ends the run
  task automatic wt(input int s, input logic v);
    for (int i = 0; i < 300 && pick(s) !== v; i++)
      step();
    if (pick(s) !== v)
    begin
      mismatches++;
      $display("wrong value wait %0d expected %b seen %b", s, v, pick(s));
      results();
    end
  endtask
  task automatic acc(input logic wr, input logic [5:0] sel, input logic [7:0] d);
    @(posedge core_clk);
    chip_select_n    <= 1'b0;
    rw_in            <= ~wr;
    register_select  <= sel;
    host_data_bus_in <= d;
    strobe_in_n      <= wr && bus_mode_strap;
    we_in_n          <= !(wr && bus_mode_strap);
    wt(0, 1'b0);
    rd = host_data_bus_out;
    chk("ready_out_n", 1'b0, ready_out_n);
    @(posedge core_clk);
    chip_select_n <= 1'b1;
    strobe_in_n   <= 1'b1;
    we_in_n       <= 1'b1;
    wt(0, 1'b1);
  endtask
  task automatic mem(input logic pf);
    wt(4, 1'b0);
    dd = host_data_bus_out;
    aa = addr_out;
    chk("rw_out", 1'b0, rw_out);
    chk("we_out_n", !bus_mode_strap, we_out_n);
    @(posedge core_clk);
    parity_fault_in <= pf;
    ready_in_n      <= 1'b0;
    wt(4, 1'b1);
    @(posedge core_clk);
    parity_fault_in <= 1'b0;
    ready_in_n      <= 1'b1;
  endtask
  task automatic grant_on;
    wt(2, 1'b0);
    @(posedge core_clk) bus_grant_n <= 1'b0;
  endtask
  task automatic grant_off;
    wt(2, 1'b1);
    @(posedge core_clk) bus_grant_n <= 1'b1;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    step();
    chk("pin_oe_n", 1'b0, pin_oe_n);
    chk("rts", 1'b1, request_to_send_n);
    acc(1'b0, SEL_CTRL, 8'h00);
    chk("ctrl", CTRL_RST, rd);
    acc(1'b0, SEL_STAT, 8'h00);
    chk("mode", 1'b0, rd[ST_MODE]);
    acc(1'b1, 6'h3f, 8'hff);
    acc(1'b0, 6'h3f, 8'h00);
    chk("unmapped", 8'h00, rd);
  endtask
  task automatic t_cs_gate;
    @(posedge core_clk) strobe_in_n <= 1'b0;
    repeat (10) step();
    chk("ready_oe_n", 1'b1, ready_oe_n);
    @(posedge core_clk) strobe_in_n <= 1'b1;
  endtask
  task automatic t_chain;
    @(posedge core_clk) chain_request_in <= 1'b0;
    wt(2, 1'b0);
    @(posedge core_clk);
    chain_request_in <= 1'b1;
    bus_grant_n      <= 1'b0;
    wt(3, 1'b0);
    @(posedge core_clk) bus_grant_n <= 1'b1;
    repeat (5) step();
    chk("chain_grant_out", 1'b1, chain_grant_out);
  endtask
  task automatic t_link;
    acc(1'b1, SEL_CTRL, 8'h01);
    repeat (20) step();
    chk("rts", 1'b1, request_to_send_n);
    @(posedge core_clk) clear_to_send_n <= 1'b0;
    repeat (8) step();
    chk("rts", 1'b0, request_to_send_n);
    repeat (400) step();
    chk("flag", 1'b1, M.flag_seen);
  endtask
  task automatic t_carrier;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk) carrier_sense_n <= ~carrier_sense_n;
      wt(1, 1'b0);
      acc(1'b0, SEL_IRQ, 8'h00);
      chk("irq", 8'h01 << IRQ_CD, rd);
      chk("irq_request_n", 1'b1, irq_request_n);
      acc(1'b0, SEL_STAT, 8'h00);
      chk("link", 1'b1, rd[ST_LINK]);
    end
  endtask
  task automatic t_dma;
    acc(1'b1, SEL_CTRL, 8'h03);
    M.send_frame(8'h5a);
    wt(2, 1'b0);
    acc(1'b0, SEL_IRQ, 8'h00);
    grant_on();
    mem(1'b1);
    repeat (10) step();
    chk("irq_request_n", 1'b1, irq_request_n);
    mem(1'b1);
    wt(1, 1'b0);
    grant_off();
    acc(1'b0, SEL_IRQ, 8'h00);
    chk("hpe", 8'h01 << IRQ_HPE, rd & (8'h01 << IRQ_HPE));
    M.send_frame(8'h3c);
    grant_on();
    mem(1'b0);
    chk("dma data", 8'h3c, dd);
    chk("dma addr", 16'h0000, aa);
    grant_off();
  endtask
  task automatic t_cts_loss;
    acc(1'b0, SEL_IRQ, 8'h00);
    @(posedge core_clk) clear_to_send_n <= 1'b1;
    wt(1, 1'b0);
    chk("rts", 1'b1, request_to_send_n);
    acc(1'b0, SEL_IRQ, 8'h00);
    chk("irq", 8'h01 << IRQ_CTS, rd);
    chk("irq_request_n", 1'b1, irq_request_n);
    @(posedge core_clk) clear_to_send_n <= 1'b0;
    repeat (8) step();
    chk("rts", 1'b0, request_to_send_n);
  endtask
  task automatic t_mode;
    @(posedge core_clk);
    rst            <= 1'b1;
    bus_mode_strap <= 1'b1;
    repeat (6) step();
    chk("pin_oe_n", 1'b1, pin_oe_n);
    chk("rts", 1'b1, request_to_send_n);
    @(posedge core_clk) rst <= 1'b0;
    acc(1'b1, SEL_CTRL, 8'h03);
    acc(1'b0, SEL_STAT, 8'h00);
    chk("mode", 1'b1, rd[ST_MODE]);
    M.send_frame(8'h66);
    grant_on();
    mem(1'b0);
    chk("dma data", 8'h66, dd);
    grant_off();
    @(posedge core_clk) bus_mode_strap <= 1'b0;
    acc(1'b0, SEL_STAT, 8'h00);
    chk("mode", 1'b1, rd[ST_MODE]);
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    mismatches = 0;
    n_checks = 0;
    rst = 1'b1;
    chip_select_n = 1'b1;
    rw_in = 1'b1;
    strobe_in_n = 1'b1;
    we_in_n = 1'b1;
    bus_mode_strap = 1'b0;
    ready_in_n = 1'b1;
    bus_grant_n = 1'b1;
    chain_request_in = 1'b1;
    parity_fault_in = 1'b0;
    carrier_sense_n = 1'b1;
    clear_to_send_n = 1'b1;
    host_data_bus_in = 8'h00;
    register_select = 6'h00;
    repeat (20) step();
    chk("pin_oe_n", 1'b1, pin_oe_n);
    @(posedge core_clk) rst <= 1'b0;
    t_reset();
    t_cs_gate();
    t_chain();
    t_link();
    t_carrier();
    t_dma();
    t_cts_loss();
    t_mode();
    results();
  end
endmodule // testbench
